// >>> verilog/cpr_pkg.sv
/*
  Constants and carrier types for the configuration memory readout port.
  Assumes a 10 MHz reference clock and a separate configuration clock.
*/
package cpr_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] LAST_ADDR = 8'hFF;
  localparam logic [ADDR_W-1:0] FIRST_ADDR = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] FIRST_BIT = 3'h0;
  localparam logic [DATA_W-1:0] OE_BYTE = 8'hFF;
  localparam logic [DATA_W-1:0] OE_SERIAL = 8'h01;
  localparam logic [DATA_W-1:0] OE_NONE = 8'h00;
  localparam logic [DATA_W-1:0] DATA_IDLE = 8'hFF;
  // Request pulse timing on the reference clock
  localparam int REF_PERIOD_NS = 100;
  localparam int REQ_MIN_NS = 300;
  localparam int REQ_MAX_NS = 500;
  localparam int REQ_MIN_CYC = (REQ_MIN_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int REQ_MAX_CYC = REQ_MAX_NS / REF_PERIOD_NS;
  localparam logic [2:0] REQ_PULSE_CYC = 3'((REQ_MIN_CYC + REQ_MAX_CYC) / 2);
  localparam logic [2:0] REQ_CNT_ZERO = 3'h0;
  localparam logic [2:0] REQ_CNT_ONE = 3'h1;

  // Control pins sampled from the loaded device side
  typedef struct packed {
    logic ce_n;
    logic oe_reset_n;
    logic busy;
    logic byte_wide_mode;
  } cpr_pins_t;

  // Programming write port into the storage array
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cpr_prog_t;
endpackage

// >>> verilog/cpr_readout_port.sv
/*
  Readout port of a configuration memory: serial and byte-wide streaming,
  cascade enable, busy hold, clock output and configuration request pulse.
  Assumes the loaded device clocks i_cfg_clock and drives the control pins;
  a board wire joins the data and request pins from their enables.
*/
// Rules of the document for this block and the devices around it
// RULE1: Serial modes shift one stored bit per valid clock edge on data bit zero.
// RULE2: Byte-wide modes present one stored byte per valid clock edge.
// RULE3: Busy high in byte-wide mode holds the byte and the counter.
// RULE4: The loaded device raises busy whenever it cannot take the next byte.
// RULE5: Output-enable/reset low clears the address counter.
// RULE6: Data outputs stay driven while chip enable stays low; the code floats them after the last data or with output-enable/reset low.
// RULE7: Chain enable output goes low to enable the next memory.
// RULE8: Done of loaded devices may drive chip enable unless grounded.
// RULE9: Request pin is two-way, only ever pulled low, otherwise released high.
// RULE10: In master modes the loaded device makes the configuration clock.
// RULE11: Master clock starts slow and may speed up by bitstream setting.
// RULE12: Slave clock comes from our clock output or an external source.
// RULE13: Chained loaded devices forward remaining serial data downstream.
// RULE14: Forwarded serial data usually changes on the falling edge.
// RULE15: Outside logic holds loader chip select and write direction low.
// RULE16: Serial chains use one master or all slaves on an external clock.
// RULE17: Only the larger variant supports byte-wide modes.
// RULE18: After the last data, chain enable goes low and outputs float.
// RULE19: Counter resets when output-enable/reset goes low or chip enable high.
// RULE20: A configuration command pulses the request pin low once for 300-500 ns.
// RULE21: While disabled, outputs float and the counter does not move.
`timescale 1ns/1ps
`default_nettype none
module cpr_readout_port #(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_cfg_clock,
  input wire cpr_pkg::cpr_pins_t i_pins,
  input wire logic i_memory_clock_out_enable,
  input wire logic i_config_cmd,
  input wire cpr_pkg::cpr_prog_t i_prog,
  input wire logic i_cfg_request_n_i,
  output logic o_cfg_request_n_o,
  output logic o_cfg_request_oe,
  output logic [cpr_pkg::DATA_W-1:0] o_data,
  output logic [cpr_pkg::DATA_W-1:0] o_data_oe,
  output logic o_chain_enable_out_n,
  output logic o_memory_clock_out
);
  // ----------------------------------------------------------------
  // Storage array, written on the reference clock only
  // ----------------------------------------------------------------
  logic [cpr_pkg::DATA_W-1:0] mem [2**cpr_pkg::ADDR_W];

  always_ff @(posedge i_ref_clk) begin
    if (i_prog.we) begin
      mem[i_prog.addr] <= i_prog.data;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: pin synchronisers
  // ----------------------------------------------------------------
  cpr_pkg::cpr_pins_t lsync1_q, lsync2_q;

  always_ff @(posedge i_cfg_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      lsync1_q <= '{ce_n: 1'b1, oe_reset_n: 1'b0, busy: 1'b0, byte_wide_mode: 1'b0};
      lsync2_q <= '{ce_n: 1'b1, oe_reset_n: 1'b0, busy: 1'b0, byte_wide_mode: 1'b0};
    end else begin
      lsync1_q <= i_pins;
      lsync2_q <= lsync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: address counter and output stage
  // ----------------------------------------------------------------
  logic [cpr_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic [2:0] bit_q, bit_d;
  logic primed_q, primed_d;
  logic done_q, done_d;
  logic ceo_n_q, ceo_n_d;
  logic [cpr_pkg::DATA_W-1:0] data_q, data_d, data_oe_q, data_oe_d;
  logic enabled, byte_mode;

  // Picks what the pins show for a given address and bit position
  function automatic logic [cpr_pkg::DATA_W-1:0] pick(
    input logic [cpr_pkg::DATA_W-1:0] word, input logic [2:0] bpos, input logic bw);
    logic [2:0] sel;
    sel = cpr_pkg::LAST_BIT - bpos;
    pick = bw ? word : {{(cpr_pkg::DATA_W-1){1'b0}}, word[sel]};
  endfunction

  assign enabled = !lsync2_q.ce_n && lsync2_q.oe_reset_n;
  assign byte_mode = lsync2_q.byte_wide_mode && LARGE_VARIANT; // RULE17

  always_comb begin
    addr_d = addr_q;
    bit_d = bit_q;
    primed_d = primed_q;
    done_d = done_q;
    ceo_n_d = ceo_n_q;
    data_d = data_q;
    data_oe_d = data_oe_q;
    if (!enabled) begin
      // Counter back to the first address, pins released
      addr_d = cpr_pkg::FIRST_ADDR; // RULE5 RULE19
      bit_d = cpr_pkg::FIRST_BIT;
      primed_d = 1'b0;
      done_d = 1'b0;
      ceo_n_d = 1'b1;
      data_d = cpr_pkg::DATA_IDLE;
      data_oe_d = cpr_pkg::OE_NONE; // RULE21
    end else if (done_q) begin
      ceo_n_d = 1'b0; // RULE7 RULE18
      data_oe_d = cpr_pkg::OE_NONE; // RULE18
    end else if (!primed_q) begin
      // First edge after enable only presents the first word
      primed_d = 1'b1;
      data_d = pick(mem[addr_q], bit_q, byte_mode);
      data_oe_d = byte_mode ? cpr_pkg::OE_BYTE : cpr_pkg::OE_SERIAL; // RULE6
    end else if (byte_mode && lsync2_q.busy) begin
      data_d = data_q; // RULE3
    end else if (byte_mode) begin
      if (addr_q == cpr_pkg::LAST_ADDR) begin
        done_d = 1'b1; // RULE18
      end else begin
        addr_d = addr_q + 1'b1; // RULE2
        data_d = pick(mem[addr_d], bit_q, 1'b1);
      end
    end else begin
      if (bit_q == cpr_pkg::LAST_BIT && addr_q == cpr_pkg::LAST_ADDR) begin
        done_d = 1'b1; // RULE18
      end else begin
        bit_d = bit_q + 1'b1; // RULE1
        if (bit_q == cpr_pkg::LAST_BIT) begin
          addr_d = addr_q + 1'b1; // RULE1
        end
        data_d = pick(mem[addr_d], bit_d, 1'b0);
      end
    end
  end

  always_ff @(posedge i_cfg_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_q <= cpr_pkg::FIRST_ADDR;
      bit_q <= cpr_pkg::FIRST_BIT;
      primed_q <= 1'b0;
      done_q <= 1'b0;
      ceo_n_q <= 1'b1;
      data_q <= cpr_pkg::DATA_IDLE;
      data_oe_q <= cpr_pkg::OE_NONE;
    end else begin
      addr_q <= addr_d;
      bit_q <= bit_d;
      primed_q <= primed_d;
      done_q <= done_d;
      ceo_n_q <= ceo_n_d;
      data_q <= data_d;
      data_oe_q <= data_oe_d;
    end
  end

  assign o_data = data_q;
  assign o_data_oe = data_oe_q;
  assign o_chain_enable_out_n = ceo_n_q;

  // ----------------------------------------------------------------
  // Reference domain: clock output and request pulse
  // ----------------------------------------------------------------
  logic [2:0] rsync1_q, rsync2_q;
  logic clk_out_q, clk_out_d;
  logic [2:0] req_cnt_q, req_cnt_d;
  logic req_oe_q, req_oe_d;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rsync1_q <= 3'h0;
      rsync2_q <= 3'h0;
    end else begin
      rsync1_q <= {i_memory_clock_out_enable && LARGE_VARIANT, !i_pins.ce_n && i_pins.oe_reset_n,
                   i_cfg_request_n_i};
      rsync2_q <= rsync1_q;
    end
  end

  always_comb begin
    // Divided clock only while enabled; parked low otherwise
    clk_out_d = (rsync2_q[2] && rsync2_q[1]) ? !clk_out_q : 1'b0; // RULE12
    req_cnt_d = req_cnt_q;
    req_oe_d = req_oe_q;
    if (req_oe_q) begin
      req_cnt_d = req_cnt_q - cpr_pkg::REQ_CNT_ONE;
      req_oe_d = (req_cnt_q != cpr_pkg::REQ_CNT_ONE); // RULE20
    end else if (i_config_cmd && rsync2_q[0]) begin
      // A line already held low elsewhere needs no second pulse
      req_oe_d = 1'b1; // RULE20
      req_cnt_d = cpr_pkg::REQ_PULSE_CYC;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_out_q <= 1'b0;
      req_cnt_q <= cpr_pkg::REQ_CNT_ZERO;
      req_oe_q <= 1'b0;
    end else begin
      clk_out_q <= clk_out_d;
      req_cnt_q <= req_cnt_d;
      req_oe_q <= req_oe_d;
    end
  end

  assign o_memory_clock_out = clk_out_q;
  assign o_cfg_request_oe = req_oe_q; // RULE9
  assign o_cfg_request_n_o = 1'b0; // RULE9

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_req_low;
    o_cfg_request_oe [*4];
  endsequence

  property p_reset_clears;
    @(posedge i_cfg_clock) disable iff (!i_nrst)
      !lsync2_q.oe_reset_n |=> addr_q == cpr_pkg::FIRST_ADDR && !primed_q;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("counter not cleared"); // RULE5

  property p_ce_high;
    @(posedge i_cfg_clock) disable iff (!i_nrst)
      lsync2_q.ce_n |=> addr_q == cpr_pkg::FIRST_ADDR && ceo_n_q && data_oe_q == 8'h00;
  endproperty
  a_ce_high: assert property (p_ce_high) else $error("disabled port still active"); // RULE21

  property p_busy_hold;
    @(posedge i_cfg_clock) disable iff (!i_nrst)
      enabled && primed_q && !done_q && byte_mode && lsync2_q.busy
      |=> $stable(data_q) && $stable(addr_q);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("moved while busy"); // RULE3

  property p_byte_step;
    @(posedge i_cfg_clock) disable iff (!i_nrst)
      enabled && primed_q && !done_q && byte_mode && !lsync2_q.busy && addr_q != 8'hFF
      |=> addr_q == $past(addr_q) + 8'h01 && data_q == mem[addr_q];
  endproperty
  a_byte_step: assert property (p_byte_step) else $error("byte step wrong"); // RULE2

  property p_bit_step;
    @(posedge i_cfg_clock) disable iff (!i_nrst)
      enabled && primed_q && !done_q && !byte_mode && !(bit_q == 3'h7 && addr_q == 8'hFF)
      |=> bit_q == $past(bit_q) + 3'h1 && data_oe_q == 8'h01;
  endproperty
  a_bit_step: assert property (p_bit_step) else $error("serial step wrong"); // RULE1

  property p_drive;
    @(posedge i_cfg_clock) disable iff (!i_nrst)
      primed_q && !done_q |-> data_oe_q != 8'h00;
  endproperty
  a_drive: assert property (p_drive) else $error("data not driven"); // RULE6

  property p_last;
    @(posedge i_cfg_clock) disable iff (!i_nrst)
      done_q && enabled |=> !ceo_n_q && data_oe_q == 8'h00;
  endproperty
  a_last: assert property (p_last) else $error("cascade hand-off wrong"); // RULE18

  property p_small;
    @(posedge i_cfg_clock) disable iff (!i_nrst)
      !LARGE_VARIANT |-> data_oe_q[7:1] == 7'h00;
  endproperty
  a_small: assert property (p_small) else $error("byte mode on small variant"); // RULE17

  property p_req_pulse;
    @(posedge i_ref_clk) disable iff (!i_nrst)
      $rose(o_cfg_request_oe) |-> s_req_low ##1 !o_cfg_request_oe;
  endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("request pulse length"); // RULE20
endmodule
`default_nettype wire

// >>> bench/cpr_loader_model.sv
/*
  Behavioural model of the loaded device's configuration logic.
  Assumes the bench switches the clock on and asks for flow-control holds.
*/
`timescale 1ns/1ps
`default_nettype none
module cpr_loader_model (
  input wire logic i_run,
  input wire logic i_hold,
  input wire logic i_din,
  output logic o_cfg_clock,
  output logic o_busy,
  output logic o_dout
);
  // Chip select and write direction held low, as board pull-downs would
  logic loader_cs_n = 1'b0;
  logic loader_write_dir_n = 1'b0;
  logic cap_q = 1'b1;

  // ----------------------------------------
  // Link clock and flow control
  // ----------------------------------------
  // Offset start keeps the link edges clear of the reference edges
  initial begin
    o_cfg_clock = 1'b0;
    o_busy = 1'b0;
    #17;
    forever begin
      #80;
      // Stays at its slow default rate; the bench never asks for the speed-up
      o_cfg_clock = i_run ? ~o_cfg_clock : 1'b0;
    end
  end

  // Busy changes just after a rising edge, never between edges
  always @(posedge o_cfg_clock) begin
    o_busy <= #2 i_hold;
  end

  // Bit taken on the rising edge, passed downstream after the falling edge
  always @(posedge o_cfg_clock) begin
    if (!loader_cs_n && !loader_write_dir_n) begin
      cap_q <= i_din;
    end
  end

  always @(negedge o_cfg_clock) begin
    o_dout <= #1 cap_q;
  end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
/*
  Self-checking bench for the configuration memory readout port.
  Assumes cpr_loader_model supplies the link clock and busy.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_ref_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic ce_n = 1'b1;
  logic oe_rst_n = 1'b0;
  logic byte_mode = 1'b0;
  logic hold = 1'b0;
  logic cmd = 1'b0;
  logic memory_clock_out_en = 1'b0;
  cpr_pkg::cpr_prog_t prog = '0;
  logic cfg_clk, busy, req_n, req_oe, ceo_n, mclk, dout, mclk_prev;
  logic [7:0] data, data_oe, small_oe;
  int mismatches = 0;
  int compares = 0;
  int idx, held, k;

  always #50 i_ref_clk = ~i_ref_clk;

  cpr_loader_model partner (.i_run(1'b1), .i_hold(hold), .i_din(data[0]),
    .o_cfg_clock(cfg_clk), .o_busy(busy), .o_dout(dout));

  // Request wire is open drain with a pull-up
  cpr_readout_port dut (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_cfg_clock(cfg_clk),
    .i_pins(cpr_pkg::cpr_pins_t'({ce_n, oe_rst_n, busy, byte_mode})),
    .i_memory_clock_out_enable(memory_clock_out_en), .i_config_cmd(cmd), .i_prog(prog),
    .i_cfg_request_n_i(req_oe ? 1'b0 : 1'b1), .o_cfg_request_n_o(req_n),
    .o_cfg_request_oe(req_oe), .o_data(data), .o_data_oe(data_oe),
    .o_chain_enable_out_n(ceo_n), .o_memory_clock_out(mclk)
  );

  // Smaller variant on the same pins: byte-wide requests must stay serial
  cpr_readout_port #(.LARGE_VARIANT(1'b0)) dut_small (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_cfg_clock(cfg_clk),
    .i_pins(cpr_pkg::cpr_pins_t'({ce_n, oe_rst_n, busy, byte_mode})),
    .i_memory_clock_out_enable(memory_clock_out_en), .i_config_cmd(cmd), .i_prog(prog),
    .i_cfg_request_n_i(req_oe ? 1'b0 : 1'b1), .o_cfg_request_n_o(),
    .o_cfg_request_oe(), .o_data(), .o_data_oe(small_oe),
    .o_chain_enable_out_n(), .o_memory_clock_out()
  );

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  function automatic logic [7:0] pat(input int a);
    return 8'(a) ^ 8'h5A;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
    #5;
  endtask

  task automatic wait_oe(input logic [7:0] v);
    k = 0;
    do begin
      @(negedge cfg_clk);
      k++;
    end while (data_oe !== v && k < 40);
    if (data_oe !== v) begin
      mismatches++;
      complete_run();
    end
  endtask

  // Forwarded bit lags the pins by two edges: taken on one, shown after the next fall
  task automatic serial_bits(input int nbits);
    logic [7:0] w;
    logic e1, e2;
    wait_oe(8'h01);
    for (int b = 0; b < nbits; b++) begin
      w = pat(b / 8);
      check(data, {7'h00, w[7 - b % 8]});
      if (b >= 2) begin
        check({7'h00, dout}, {7'h00, e2});
      end
      e2 = e1;
      e1 = w[7 - b % 8];
      @(negedge cfg_clk);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Whole memory byte-wide, with a four-edge busy hold in mid-stream
  task automatic byte_stream();
    tick(1);
    {byte_mode, memory_clock_out_en, ce_n, oe_rst_n} = 4'hD;
    wait_oe(8'hFF);
    check(small_oe, 8'h01);
    idx = 0;
    held = 0;
    for (int n = 0; n < 400 && data_oe === 8'hFF; n++) begin
      hold = (n >= 100 && n < 104);
      if (data !== pat(idx)) begin
        idx++;
        check(data, pat(idx));
      end else begin
        held++;
      end
      @(negedge cfg_clk);
    end
    check(8'(idx), 8'hFF);
    check(8'(held), 8'h06);
    check({7'h00, ceo_n}, 8'h00);
    check(data_oe, 8'h00);
  endtask

  // Serial restart after each kind of disable; busy is ignored here
  task automatic serial_stream();
    tick(1);
    oe_rst_n = 1'b0;
    // Two synchroniser stages plus the applying edge
    repeat (4) @(negedge cfg_clk);
    check(data_oe, 8'h00);
    check({7'h00, ceo_n}, 8'h01);
    tick(1);
    {byte_mode, hold, oe_rst_n} = 3'h3;
    serial_bits(16);
    tick(1);
    ce_n = 1'b1;
    wait_oe(8'h00);
    check({7'h00, ceo_n}, 8'h01);
    tick(4);
    check({7'h00, mclk}, 8'h00);
    {ce_n, hold} = 2'h0;
    serial_bits(8);
    tick(1);
    mclk_prev = mclk;
    tick(1);
    check({7'h00, mclk}, {7'h00, ~mclk_prev});
  endtask

  // One command gives one pulse; a second one during the pulse is dropped
  task automatic request_pulse();
    tick(1);
    cmd = 1'b1;
    tick(1);
    held = 0;
    for (int c = 0; c < 10; c++) begin
      cmd = (c == 2);
      if (req_oe === 1'b1) begin
        held++;
      end
      tick(1);
    end
    check(8'(held), 8'h04);
    check({7'h00, req_n}, 8'h00);
  endtask

  initial begin
    tick(10);
    i_nrst = 1'b1;
    for (int a = 0; a < 256; a++) begin
      prog = {1'b1, 8'(a), pat(a)};
      tick(1);
    end
    prog = '0;
    byte_stream();
    serial_stream();
    request_pulse();
    complete_run();
  end
endmodule
`default_nettype wire
